// *** rtl/st_wdg_pkg.sv ***
// constants and types for the converter self-test supervisor
// Operation
// - threshold check enable per error kind
// - watchdog timer enable per algorithm
// - watchdog timeout value software programmable
// - capture failing test data per error kind
// - watchdog runs only in scan mode
// - fresh flag set on result, cleared on read
// - overwrite unread result sets lost flag
// - interrupt enables set or cleared by mask
// - all status flags readable as one word
// - clear selected status flags by mask
// - test data readable during steps 0, 2, C
// - test conversions only in normal sequences
// - nine self-test interrupt sources
package st_wdg_pkg;
  localparam int DATA_W = 16;
  localparam int TMR_W = 16;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int NUM_SRC = 9;
  localparam int NUM_KIND = 5;
  // status / enable bit positions
  localparam int BIT_FIRST_ALG_STEP0_FAULT = 0;
  localparam int BIT_ERR_S1 = 1;
  localparam int BIT_FIRST_ALG_STEP2_FAULT = 2;
  localparam int BIT_ERR_C = 3;
  localparam int BIT_END_S = 4;
  localparam int BIT_END_C = 5;
  localparam int BIT_CONV_END = 6;
  localparam int BIT_WDG_TIME = 7;
  localparam int BIT_WDG_SEQ = 8;
  // capture / threshold kinds
  localparam int KIND_S0 = 0;
  localparam int KIND_S1I = 1;
  localparam int KIND_S1F = 2;
  localparam int KIND_S2 = 3;
  localparam int KIND_C = 4;
  localparam logic [NUM_SRC-1:0] IEN_RST = 9'h000;
  localparam logic [TMR_W-1:0] TMR_RST = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  // step codes of the running algorithm
  typedef enum logic [2:0] {
    STEP_IDLE, STEP_S0, STEP_S1, STEP_S2, STEP_C
  } step_t;
endpackage

// *** rtl/result_flags.sv ***
// per-channel fresh and lost-data flags of the result words
`timescale 1ns/1ps
module result_flags (
  input wire logic mclk,
  input wire logic srst,
  input wire logic conv_done,
  input wire logic [st_wdg_pkg::CH_W-1:0] conv_ch,
  input wire logic rd_strobe,
  input wire logic [st_wdg_pkg::CH_W-1:0] rd_ch,
  output logic [st_wdg_pkg::NUM_CH-1:0] fresh,
  output logic [st_wdg_pkg::NUM_CH-1:0] lost
);
  typedef struct packed {
    logic [st_wdg_pkg::NUM_CH-1:0] fresh;
    logic [st_wdg_pkg::NUM_CH-1:0] lost;
  } rf_state_t;
  rf_state_t st_ff;
  rf_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    for (int i = 0; i < st_wdg_pkg::NUM_CH; i++) begin
      // read clears first, so a same-cycle completion still wins
      if (rd_strobe && rd_ch == i[st_wdg_pkg::CH_W-1:0]) begin
        nxt_st.fresh[i] = 1'b0;
        nxt_st.lost[i] = 1'b0;
      end
      if (conv_done && conv_ch == i[st_wdg_pkg::CH_W-1:0]) begin
        nxt_st.fresh[i] = 1'b1;
        // unread previous value is dropped
        if (st_ff.fresh[i] && !(rd_strobe && rd_ch == conv_ch)) begin
          nxt_st.lost[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign fresh = st_ff.fresh;
  assign lost = st_ff.lost;
endmodule

// *** rtl/adc_self_test_watchdog.sv ***
// self-test supervisor: thresholds, watchdog, capture, status flags
`timescale 1ns/1ps
module adc_self_test_watchdog (
  input wire logic mclk,
  input wire logic srst,
  input wire logic self_test_enable,
  input wire logic scan_mode,
  input wire logic injected_active,
  input wire logic [st_wdg_pkg::NUM_KIND-1:0] thr_enable,
  input wire logic wdg_en_s,
  input wire logic wdg_en_c,
  input wire logic [st_wdg_pkg::TMR_W-1:0] wdg_timeout,
  input wire logic [st_wdg_pkg::DATA_W-1:0] thr_low,
  input wire logic [st_wdg_pkg::DATA_W-1:0] thr_high,
  input wire logic test_conv_done,
  input wire st_wdg_pkg::step_t test_step,
  input wire logic step1_fraction,
  input wire logic [st_wdg_pkg::DATA_W-1:0] test_data,
  input wire logic alg_s_end,
  input wire logic alg_c_end,
  input wire logic seq_error,
  input wire logic ien_set_strobe,
  input wire logic ien_clr_strobe,
  input wire logic [st_wdg_pkg::NUM_SRC-1:0] ien_mask,
  input wire logic stat_clr_strobe,
  input wire logic [st_wdg_pkg::NUM_SRC-1:0] stat_clr_mask,
  input wire logic [2:0] cap_sel,
  input wire logic conv_done,
  input wire logic [st_wdg_pkg::CH_W-1:0] conv_ch,
  input wire logic rd_strobe,
  input wire logic [st_wdg_pkg::CH_W-1:0] rd_ch,
  output logic [st_wdg_pkg::NUM_SRC-1:0] int_status,
  output logic [st_wdg_pkg::NUM_SRC-1:0] int_enable,
  output logic st_irq,
  output logic [st_wdg_pkg::DATA_W-1:0] fail_data,
  output logic [st_wdg_pkg::DATA_W-1:0] test_data_out,
  output logic test_data_valid,
  output logic [st_wdg_pkg::NUM_CH-1:0] result_fresh,
  output logic [st_wdg_pkg::NUM_CH-1:0] result_lost_flag
);
  // ********************************************
  // state
  // ********************************************
  typedef struct packed {
    logic [st_wdg_pkg::NUM_SRC-1:0] stat;
    logic [st_wdg_pkg::NUM_SRC-1:0] ien;
    logic irq;
    logic [st_wdg_pkg::NUM_KIND-1:0][st_wdg_pkg::DATA_W-1:0] cap;
    logic [st_wdg_pkg::DATA_W-1:0] fail;
    logic [st_wdg_pkg::DATA_W-1:0] live;
    logic live_vld;
    logic [st_wdg_pkg::TMR_W-1:0] tmr;
    logic s_run;
    logic c_run;
  } st_state_t;
  st_state_t st_ff;
  st_state_t nxt_st;

  logic [st_wdg_pkg::NUM_SRC-1:0] ev;
  logic test_ok;
  logic out_of_range;
  logic [2:0] kind;
  logic wdg_active;

  // ********************************************
  // events and next state
  // ********************************************
  always_comb begin
    nxt_st = st_ff;
    ev = '0;
    kind = 3'h0;
    // injected conversions never carry a test channel
    test_ok = test_conv_done && self_test_enable && !injected_active;
    out_of_range = (test_data < thr_low) || (test_data > thr_high);
    case (test_step)
      st_wdg_pkg::STEP_S0: kind = 3'(st_wdg_pkg::KIND_S0);
      st_wdg_pkg::STEP_S1: kind = step1_fraction ?
        3'(st_wdg_pkg::KIND_S1F) : 3'(st_wdg_pkg::KIND_S1I);
      st_wdg_pkg::STEP_S2: kind = 3'(st_wdg_pkg::KIND_S2);
      st_wdg_pkg::STEP_C: kind = 3'(st_wdg_pkg::KIND_C);
      default: kind = 3'h0;
    endcase
    if (test_ok && test_step != st_wdg_pkg::STEP_IDLE) begin
      ev[st_wdg_pkg::BIT_CONV_END] = 1'b1;
      if (thr_enable[kind] && out_of_range) begin
        nxt_st.cap[kind] = test_data;
        case (test_step)
          st_wdg_pkg::STEP_S0: ev[st_wdg_pkg::BIT_FIRST_ALG_STEP0_FAULT] = 1'b1;
          st_wdg_pkg::STEP_S1: ev[st_wdg_pkg::BIT_ERR_S1] = 1'b1;
          st_wdg_pkg::STEP_S2: ev[st_wdg_pkg::BIT_FIRST_ALG_STEP2_FAULT] = 1'b1;
          default: ev[st_wdg_pkg::BIT_ERR_C] = 1'b1;
        endcase
      end
      // live view only for steps that expose it
      if (test_step != st_wdg_pkg::STEP_S1) begin
        nxt_st.live = test_data;
        nxt_st.live_vld = 1'b1;
      end else begin
        nxt_st.live_vld = 1'b0;
      end
    end
    if (!self_test_enable) begin
      nxt_st.live_vld = 1'b0;
    end
    ev[st_wdg_pkg::BIT_END_S] = alg_s_end && self_test_enable;
    ev[st_wdg_pkg::BIT_END_C] = alg_c_end && self_test_enable;
    ev[st_wdg_pkg::BIT_WDG_SEQ] = seq_error && self_test_enable;

    // watchdog: one timer, runs while an enabled algorithm is pending
    if (test_ok && (test_step == st_wdg_pkg::STEP_S0 ||
        test_step == st_wdg_pkg::STEP_C) && st_ff.tmr == '0) begin
      nxt_st.s_run = st_ff.s_run || (test_step == st_wdg_pkg::STEP_S0);
      nxt_st.c_run = st_ff.c_run || (test_step == st_wdg_pkg::STEP_C);
    end
    if (alg_s_end) begin
      nxt_st.s_run = 1'b0;
    end
    if (alg_c_end) begin
      nxt_st.c_run = 1'b0;
    end
    // one-shot mode leaves the timer parked
    wdg_active = scan_mode && self_test_enable &&
      ((st_ff.s_run && wdg_en_s) || (st_ff.c_run && wdg_en_c));
    if (!wdg_active || alg_s_end || alg_c_end) begin
      nxt_st.tmr = '0;
    end else if (st_ff.tmr >= wdg_timeout - 16'h0001) begin
      ev[st_wdg_pkg::BIT_WDG_TIME] = 1'b1;
      nxt_st.tmr = '0;
      nxt_st.s_run = 1'b0;
      nxt_st.c_run = 1'b0;
    end else begin
      nxt_st.tmr = st_ff.tmr + 16'h0001;
    end

    // enables: clear mask then set mask, so a set beats a clear
    if (ien_clr_strobe) begin
      nxt_st.ien = nxt_st.ien & ~ien_mask;
    end
    if (ien_set_strobe) begin
      nxt_st.ien = nxt_st.ien | ien_mask;
    end
    // a new event beats a clear in the same cycle
    if (stat_clr_strobe) begin
      nxt_st.stat = st_ff.stat & ~stat_clr_mask;
    end
    nxt_st.stat = nxt_st.stat | ev;
    nxt_st.irq = |(nxt_st.stat & nxt_st.ien);
    nxt_st.fail = (cap_sel < 3'(st_wdg_pkg::NUM_KIND)) ?
      nxt_st.cap[cap_sel] : st_wdg_pkg::DATA_RST;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.ien <= st_wdg_pkg::IEN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************************************
  // result flags
  // ********************************************
  result_flags u_flags (
    .mclk(mclk),
    .srst(srst),
    .conv_done(conv_done),
    .conv_ch(conv_ch),
    .rd_strobe(rd_strobe),
    .rd_ch(rd_ch),
    .fresh(result_fresh),
    .lost(result_lost_flag)
  );

  assign int_status = st_ff.stat;
  assign int_enable = st_ff.ien;
  assign st_irq = st_ff.irq;
  assign fail_data = st_ff.fail;
  assign test_data_out = st_ff.live;
  assign test_data_valid = st_ff.live_vld;
endmodule

// *** test/st_wdg_sva.sv ***
// port checker of the self-test supervisor
`timescale 1ns/1ps
module st_wdg_sva (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scan_mode,
  input wire logic injected_active,
  input wire logic ien_set_strobe,
  input wire logic ien_clr_strobe,
  input wire logic [8:0] ien_mask,
  input wire logic stat_clr_strobe,
  input wire logic [8:0] int_status,
  input wire logic [8:0] int_enable,
  input wire logic st_irq,
  input wire logic conv_done,
  input wire logic [2:0] conv_ch,
  input wire logic rd_strobe,
  input wire logic [2:0] rd_ch,
  input wire logic [7:0] result_fresh,
  input wire logic [7:0] result_lost_flag
);
  // ****
  // rules at the ports
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_ien_set: assert property (ien_set_strobe |=>
    (int_enable & $past(ien_mask)) == $past(ien_mask)) else $error("set");
  a_ien_clr: assert property (ien_clr_strobe && !ien_set_strobe |=>
    (int_enable & $past(ien_mask)) == 9'h000) else $error("clear");
  a_stat_sticky: assert property (!stat_clr_strobe |=>
    (int_status & $past(int_status)) == $past(int_status)) else $error("drop");
  a_irq_follow: assert property (|(int_status & int_enable) |->
    ##[0:1] st_irq) else $error("irq missing");
  a_inj_quiet: assert property (injected_active && !int_status[6] |=>
    !int_status[6]) else $error("injected test conversion");
  a_wdg_oneshot: assert property (!scan_mode && !int_status[7] |=>
    !int_status[7]) else $error("watchdog in one-shot");
  a_fresh_clr: assert property (rd_strobe &&
    !(conv_done && conv_ch == rd_ch) |=> !result_fresh[$past(rd_ch)])
    else $error("fresh kept");
  a_lost_set: assert property (conv_done && result_fresh[conv_ch] &&
    !(rd_strobe && rd_ch == conv_ch) |=> result_lost_flag[$past(conv_ch)])
    else $error("lost missing");
  // rare paths worth seeing hit
  c_wdg: cover property (int_status[7]);
  c_lost: cover property (|result_lost_flag);
  c_irq: cover property (st_irq);
endmodule
bind adc_self_test_watchdog st_wdg_sva u_sva (.mclk, .srst, .scan_mode,
  .injected_active, .ien_set_strobe, .ien_clr_strobe, .ien_mask,
  .stat_clr_strobe, .int_status, .int_enable, .st_irq, .conv_done, .conv_ch,
  .rd_strobe, .rd_ch, .result_fresh, .result_lost_flag);

// *** test/adc_self_test_watchdog_tb.sv ***
// self-checking bench of the self-test supervisor
`timescale 1ns/1ps
module adc_self_test_watchdog_tb;
  logic mclk, srst, self_test_enable, scan_mode, injected_active, wdg_en_s;
  logic wdg_en_c, test_conv_done, step1_fraction, alg_s_end, alg_c_end;
  logic seq_error, ien_set_strobe, ien_clr_strobe, stat_clr_strobe;
  logic conv_done, rd_strobe, st_irq, test_data_valid;
  logic [4:0] thr_enable;
  logic [15:0] wdg_timeout, thr_low, thr_high, test_data, fail_data, d;
  logic [15:0] test_data_out;
  logic [8:0] ien_mask, stat_clr_mask, int_status, int_enable, m;
  logic [2:0] cap_sel, conv_ch, rd_ch;
  logic [7:0] result_fresh, result_lost_flag;
  st_wdg_pkg::step_t test_step;
  logic [18:0] exp_q[$];
  logic [18:0] cur;
  int mismatches, checks, k, b;
  adc_self_test_watchdog dut (.*);
  // ****
  // clock, tasks and result watcher
  // ****
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task tick(int n);
    repeat (n) @(posedge mclk);
  endtask
  task note(logic [2:0] s, logic [15:0] v);
    exp_q.push_back({s, v});
  endtask
  task chk_word(logic [15:0] g, logic [15:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_bit(logic g, logic e);
    chk_word({15'h0000, g}, {15'h0000, e});
  endtask
  task conv(logic [2:0] s, logic [15:0] v);
    test_step <= st_wdg_pkg::step_t'(s);
    test_data <= v;
    test_conv_done <= 1'b1;
    tick(1);
    test_conv_done <= 1'b0;
    tick(2);
  endtask
  task clr(logic [8:0] c);
    stat_clr_mask <= c;
    stat_clr_strobe <= 1'b1;
    tick(1);
    stat_clr_strobe <= 1'b0;
    tick(2);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // outputs are settled by the falling edge
  always @(negedge mclk) begin
    while (exp_q.size() > 0) begin
      cur = exp_q.pop_front();
      case (cur[18:16])
        3'h0: chk_word({7'h00, int_status}, cur[15:0]);
        3'h1: chk_word({7'h00, int_enable}, cur[15:0]);
        3'h2: chk_word(fail_data, cur[15:0]);
        3'h3: chk_word({8'h00, result_fresh}, cur[15:0]);
        3'h4: chk_word({8'h00, result_lost_flag}, cur[15:0]);
        3'h5: chk_bit(st_irq, cur[0]);
        3'h6: chk_word(test_data_out, cur[15:0]);
        default: chk_bit(test_data_valid, cur[0]);
      endcase
    end
  end
  initial begin
    tick(2000);
    mismatches++;
    $display("mismatch at %0t: timeout", $time);
    print_verdict;
  end
  initial begin
    {srst, scan_mode, injected_active, wdg_en_s, wdg_en_c, test_conv_done,
     step1_fraction, alg_s_end, alg_c_end, seq_error, ien_set_strobe,
     ien_clr_strobe, stat_clr_strobe, conv_done, rd_strobe, thr_enable,
     test_data, ien_mask, stat_clr_mask, cap_sel, conv_ch,
     rd_ch} = '0;
    srst = 1'b1;
    // held high for the whole run, never toggled mid-conversion
    self_test_enable = 1'b1;
    {thr_low, thr_high, wdg_timeout} = {16'h0064, 16'h00C8, 16'h0014};
    test_step = st_wdg_pkg::STEP_IDLE;
    void'($urandom(32'hB900));
    tick(20);
    srst <= 1'b0;
    tick(1);
    note(0, 0);
    m = 9'($urandom);
    {ien_mask, ien_set_strobe} <= {m, 1'b1};
    tick(1);
    {ien_mask, ien_set_strobe, ien_clr_strobe} <= {9'h0AA, 2'b01};
    tick(1);
    ien_clr_strobe <= 1'b0;
    tick(2);
    note(1, {7'h00, m & 9'h155});
    {ien_mask, ien_set_strobe} <= {9'h1FF, 1'b1};
    tick(1);
    ien_set_strobe <= 1'b0;
    $display("enable test done");
    // every step kind: error, capture, partial clear, then disabled check
    for (k = 0; k < 5; k++) begin
      d = 16'h0100 + 16'($urandom % 4096);
      b = k - int'(k > 1);
      {thr_enable, step1_fraction, cap_sel} <= {5'h01 << k, k == 2, 3'(k)};
      conv(3'(b + 1), d);
      note(0, 16'h0040 | (16'h0001 << b));
      note(2, d);
      note(5, 1);
      note(7, 16'(b != 1));
      if (b != 1) note(6, d);
      clr(9'h001 << b);
      note(0, 16'h0040);
      clr(9'h1FF);
      thr_enable <= 5'h00;
      conv(3'(b + 1), d);
      note(0, 16'h0040);
      clr(9'h1FF);
    end
    {thr_enable, injected_active} <= {5'h1F, 1'b1};
    conv(3'h1, 16'hFFFF);
    note(0, 0);
    {thr_enable, injected_active} <= 6'h00;
    for (k = 0; k < 3; k++) begin
      {seq_error, alg_c_end, alg_s_end} <= 3'b001 << k;
      tick(1);
      {seq_error, alg_c_end, alg_s_end} <= 3'b000;
      tick(2);
      note(0, k < 2 ? 16'h0010 << k : 16'h0100);
      clr(9'h1FF);
    end
    $display("threshold and event tests done");
    // in-range data so only the watchdog can flag an error
    for (k = 0; k < 3; k++) begin
      {scan_mode, wdg_en_s, wdg_en_c} <= {k != 1, k < 2, k == 2};
      conv(k == 2 ? 3'h4 : 3'h1, 16'h0096);
      tick(30);
      note(0, k == 1 ? 16'h0040 : 16'h00C0);
      {alg_c_end, alg_s_end} <= 2'b11;
      tick(1);
      {alg_c_end, alg_s_end} <= 2'b00;
      clr(9'h1FF);
    end
    $display("watchdog test done");
    {conv_ch, conv_done} <= {3'($urandom), 1'b1};
    tick(2);
    conv_done <= 1'b0;
    tick(2);
    note(3, 16'h0001 << conv_ch);
    note(4, 16'h0001 << conv_ch);
    {rd_ch, rd_strobe} <= {conv_ch, 1'b1};
    tick(1);
    rd_strobe <= 1'b0;
    tick(2);
    note(3, 0);
    tick(2);
    $display("result flag test done");
    print_verdict;
  end
endmodule
